// >>> shared/fbc_pkg.sv
// constants of the bus configuration register bank
package fbc_pkg;

    // register port addresses
    localparam logic [3:0] FBC_ADDR_NV = 4'h0;
    localparam logic [3:0] FBC_ADDR_NV_ERASE = 4'h1;
    localparam logic [3:0] FBC_ADDR_VCR = 4'h2;
    localparam logic [3:0] FBC_ADDR_STATUS = 4'h3;
    localparam logic [3:0] FBC_ADDR_CTRL = 4'h4;

    // field positions, shared by both configuration words
    localparam int FBC_RSV_HI_BIT = 15;
    localparam int FBC_DRIVE_HI = 14;
    localparam int FBC_DRIVE_LO = 12;
    localparam int FBC_FREEZE_BIT = 11;
    localparam int FBC_SSR_BIT = 10;
    localparam int FBC_MAP_HI = 9;
    localparam int FBC_MAP_LO = 8;
    localparam int FBC_LAT_HI = 7;
    localparam int FBC_LAT_LO = 4;
    localparam int FBC_RSV_LO_BIT = 3;
    localparam int FBC_STALL_BIT = 2;
    localparam int FBC_BURST_HI = 1;
    localparam int FBC_BURST_LO = 0;

    // status word bit positions
    localparam int FBC_ST_SRC_BIT = 0;
    localparam int FBC_ST_LOCK_BIT = 1;
    localparam int FBC_ST_PERM_BIT = 2;
    localparam int FBC_ST_REFUSED_BIT = 3;
    localparam int FBC_ST_BUSY_BIT = 4;

    // control word bit positions
    localparam int FBC_CTRL_SWRST_BIT = 0;

    // reset values
    localparam logic [15:0] FBC_FACTORY_CFG = 16'h8ebb;
    localparam logic [15:0] FBC_RSV_ONES = 16'h8008;

    // latency and burst codes
    localparam logic [4:0] FBC_LAT_BASE = 5'h05;
    localparam logic [3:0] FBC_LAT_MAX_CODE = 4'hb;
    localparam logic [1:0] FBC_BURST_64 = 2'h1;
    localparam logic [1:0] FBC_BURST_16 = 2'h2;
    localparam logic [1:0] FBC_BURST_32 = 2'h3;

    // word-address wrap masks
    localparam logic [7:0] FBC_MASK_16 = 8'h07;
    localparam logic [7:0] FBC_MASK_32 = 8'h0f;
    localparam logic [7:0] FBC_MASK_64 = 8'h1f;

    // burst sequencer states
    typedef enum logic [1:0] {
        FBC_IDLE,
        FBC_WAIT,
        FBC_DATA
    } fbc_state_t;

endpackage

// >>> verilog/fbc_nv_cell.sv
// nonvolatile configuration word storage, kept across hardware reset
`timescale 1ns/1ps
module fbc_nv_cell
    import fbc_pkg::*;
(
    // clock and power-on reset
    input wire logic clk_in,
    input wire logic por_b_in,
    // write side
    input wire logic wr_in,
    input wire logic [15:0] wdata_in,
    // read side
    output logic [15:0] rdata_out
);

    // storage only returns to factory value on power-on
    always_ff @(posedge clk_in) begin
        if (!por_b_in) begin
            rdata_out <= FBC_FACTORY_CFG;
        end else if (wr_in) begin
            rdata_out <= wdata_in;
        end
    end

endmodule

// >>> verilog/fbc_config_regs.sv
// bus configuration register bank with burst sequencer and read strobe
//
// Contract
// - after power-up or hardware reset bus settings come from the nonvolatile word
// - once the volatile word is loaded it rules; only hardware reset reverts
// - volatile word loads whenever unlocked and idle; host loads only when idle
// - bits 15 and 3 of both words are reserved and hold one
// - bits 14:12 pick one of eight drive strength codes, default 000
// - freeze bit 11 low blocks nonvolatile program/erase and volatile changes
// - bit 10 low locks the secure silicon region against programming
// - bits 9:8 select the sector map, default 10
// - bits 7:4 give read latency as code plus five clocks, capped at 16, default 16
// - bit 2 low stalls the read strobe low on dual-bit error
// - bits 1:0 pick wrap length 64, 16 or 32 bytes; 00 reserved
// - both words share the same field positions
// - freeze bits of both words set locking right after reset
// - 16, 32 and 64 byte bursts all wrap conventionally inside their window
// - nonvolatile erase, and program after a volatile load, take effect only after hardware reset
// - volatile load takes effect at once
// - nonvolatile program before any volatile load also loads the volatile word
// - software reset keeps the configuration source selection
`timescale 1ns/1ps
module fbc_config_regs
    import fbc_pkg::*;
(
    // clock and resets
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic por_b_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // device activity
    input wire logic op_busy_in,
    // read transaction side
    input wire logic txn_active_in,
    input wire logic burst_start_in,
    input wire logic burst_wrap_in,
    input wire logic [7:0] burst_addr_in,
    input wire logic dual_err_in,
    // burst outputs
    output logic [7:0] burst_addr_out,
    output logic data_phase_out,
    output logic read_write_data_strobe_out,
    // decoded bus settings
    output logic [2:0] drive_strength_out,
    output logic secure_silicon_region_locked_out,
    output logic [1:0] sector_map_out,
    output logic [4:0] read_latency_out,
    output logic [7:0] wrap_mask_out,
    output logic config_source_vcr_out,
    output logic config_locked_out
);

    // wrap mask from burst code; 00 falls back to 32 bytes
    function automatic logic [7:0] fbc_wrap_mask(input logic [1:0] code);
        logic [7:0] m;
        m = FBC_MASK_32;
        unique case (code)
            FBC_BURST_64: m = FBC_MASK_64;
            FBC_BURST_16: m = FBC_MASK_16;
            FBC_BURST_32: m = FBC_MASK_32;
            default: m = FBC_MASK_32;
        endcase
        return m;
    endfunction

    // latency in clocks from code, codes above max clamp to max
    // clamping keeps unused codes from stretching the wait past sixteen clocks
    function automatic logic [4:0] fbc_latency(input logic [3:0] code);
        logic [3:0] c;
        c = (code > FBC_LAT_MAX_CODE) ? FBC_LAT_MAX_CODE : code;
        return FBC_LAT_BASE + {1'b0, c};
    endfunction

    // stored words and selection state
    logic [15:0] nv_word;
    logic [15:0] vcr_word;
    logic vcr_loaded;
    logic perm_locked;
    logic refused;

    // burst sequencer state
    fbc_state_t state;
    logic [4:0] lat_count;
    logic [7:0] base_addr;
    logic [7:0] offset;
    logic [7:0] cur_mask;
    logic stalled;
    logic strobe;

    // decoded requests
    logic wr_nv;
    logic wr_erase;
    logic wr_vcr;
    logic wr_ctrl;
    logic sw_reset;
    logic dev_idle;
    logic cfg_locked;
    logic nv_allow;
    logic vcr_allow;
    logic nv_we;
    logic [15:0] nv_wdata;
    logic [15:0] next_cfg;

    // nonvolatile word survives hardware reset
    fbc_nv_cell u_nv (
        .clk_in(clk_in),
        .por_b_in(por_b_in),
        .wr_in(nv_we),
        .wdata_in(nv_wdata),
        .rdata_out(nv_word)
    );

    // address decode of write strobes
    assign wr_nv = reg_wr_in && (reg_addr_in == FBC_ADDR_NV);
    assign wr_erase = reg_wr_in && (reg_addr_in == FBC_ADDR_NV_ERASE);
    assign wr_vcr = reg_wr_in && (reg_addr_in == FBC_ADDR_VCR);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == FBC_ADDR_CTRL);
    assign sw_reset = wr_ctrl && reg_wdata_in[FBC_CTRL_SWRST_BIT];

    // device is idle with no embedded operation and no burst
    // a change in the middle of a burst would bend the settings it runs on
    assign dev_idle = !op_busy_in && (state == FBC_IDLE);

    // volatile freeze bit rules the lock for both words
    // after reset the copy carries the nonvolatile freeze bit, so both bits agree
    assign cfg_locked = !vcr_word[FBC_FREEZE_BIT];
    assign nv_allow = !cfg_locked && dev_idle;
    assign vcr_allow = !cfg_locked && dev_idle;

    // program writes the data, erase returns the factory word
    assign nv_we = (wr_nv || wr_erase) && nv_allow;
    assign nv_wdata = wr_erase ? FBC_FACTORY_CFG : (reg_wdata_in | FBC_RSV_ONES);

    // next volatile contents, reserved bits forced high
    assign next_cfg = reg_wdata_in | FBC_RSV_ONES;

    // volatile word: snapshot of nonvolatile at reset, then loads
    // a nonvolatile program after a volatile load reaches the bus only through this copy at reset
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            vcr_word <= nv_word;
        end else if (wr_vcr && vcr_allow) begin
            vcr_word <= next_cfg;
        end else if (nv_we && wr_nv && !vcr_loaded) begin
            vcr_word <= nv_wdata;
        end
    end

    // source selection; software reset does not touch it
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            vcr_loaded <= 1'b0;
        end else if (wr_vcr && vcr_allow) begin
            vcr_loaded <= 1'b1;
        end
    end

    // permanent lock seen whenever both freeze bits are low; hardware reset clears it unless the nonvolatile freeze bit is low
    // registered, so status shows the pair one cycle after either word moves
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            perm_locked <= 1'b0;
        end else begin
            perm_locked <= !nv_word[FBC_FREEZE_BIT] && !vcr_word[FBC_FREEZE_BIT];
        end
    end

    // sticky flag of ignored requests, set wins over software clear
    // a refusal in the same cycle as a clear must not be lost
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            refused <= 1'b0;
        end else if (((wr_nv || wr_erase) && !nv_allow) || (wr_vcr && !vcr_allow)) begin
            refused <= 1'b1;
        end else if (sw_reset) begin
            refused <= 1'b0;
        end
    end

    // register read data, one cycle after the strobe
    // idle cycles return zero so a stale word is never taken for an answer
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                FBC_ADDR_NV: reg_rdata_out <= nv_word;
                FBC_ADDR_VCR: reg_rdata_out <= vcr_word;
                FBC_ADDR_STATUS: begin
                    reg_rdata_out <= 16'h0000;
                    reg_rdata_out[FBC_ST_SRC_BIT] <= vcr_loaded;
                    reg_rdata_out[FBC_ST_LOCK_BIT] <= cfg_locked;
                    reg_rdata_out[FBC_ST_PERM_BIT] <= perm_locked;
                    reg_rdata_out[FBC_ST_REFUSED_BIT] <= refused;
                    reg_rdata_out[FBC_ST_BUSY_BIT] <= !dev_idle;
                end
                default: reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    // decoded bus settings from the active volatile word
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            drive_strength_out <= FBC_FACTORY_CFG[FBC_DRIVE_HI:FBC_DRIVE_LO];
            secure_silicon_region_locked_out <= !FBC_FACTORY_CFG[FBC_SSR_BIT];
            sector_map_out <= FBC_FACTORY_CFG[FBC_MAP_HI:FBC_MAP_LO];
            read_latency_out <= fbc_latency(FBC_FACTORY_CFG[FBC_LAT_HI:FBC_LAT_LO]);
            wrap_mask_out <= fbc_wrap_mask(FBC_FACTORY_CFG[FBC_BURST_HI:FBC_BURST_LO]);
        end else begin
            drive_strength_out <= vcr_word[FBC_DRIVE_HI:FBC_DRIVE_LO];
            secure_silicon_region_locked_out <= !vcr_word[FBC_SSR_BIT];
            sector_map_out <= vcr_word[FBC_MAP_HI:FBC_MAP_LO];
            read_latency_out <= fbc_latency(vcr_word[FBC_LAT_HI:FBC_LAT_LO]);
            wrap_mask_out <= fbc_wrap_mask(vcr_word[FBC_BURST_HI:FBC_BURST_LO]);
        end
    end

    // lock and source outputs
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            config_source_vcr_out <= 1'b0;
            config_locked_out <= 1'b0;
        end else begin
            config_source_vcr_out <= vcr_loaded;
            config_locked_out <= cfg_locked;
        end
    end

    // burst sequencer: latency wait, then data beats
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state <= FBC_IDLE;
            lat_count <= 5'h00;
        end else begin
            unique case (state)
                FBC_IDLE: begin
                    if (burst_start_in && txn_active_in) begin
                        state <= FBC_WAIT;
                        lat_count <= fbc_latency(vcr_word[FBC_LAT_HI:FBC_LAT_LO]) - 5'h01;
                    end
                end
                FBC_WAIT: begin
                    if (!txn_active_in) begin
                        state <= FBC_IDLE;
                    end else if (lat_count == 5'h00) begin
                        state <= FBC_DATA;
                    end else begin
                        lat_count <= lat_count - 5'h01;
                    end
                end
                FBC_DATA: begin
                    if (!txn_active_in) begin
                        state <= FBC_IDLE;
                    end
                end
                default: begin
                    state <= FBC_IDLE; // unused code falls back to idle
                end
            endcase
        end
    end

    // burst start address and wrap window captured per transaction
    // the window is held so a running burst keeps the length it started with
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            base_addr <= 8'h00;
            cur_mask <= 8'h00;
        end else if (state == FBC_IDLE && burst_start_in && txn_active_in) begin
            base_addr <= burst_addr_in;
            cur_mask <= burst_wrap_in ? fbc_wrap_mask(vcr_word[FBC_BURST_HI:FBC_BURST_LO]) : 8'hff;
        end
    end

    // beat offset from the start address
    // counts data beats only; the wait phase leaves it at zero
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            offset <= 8'h00;
        end else if (state == FBC_IDLE) begin
            offset <= 8'h00;
        end else if (state == FBC_DATA) begin
            offset <= offset + 8'h01;
        end
    end

    // wrapped word address: high bits fixed, low bits roll in the window
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            burst_addr_out <= 8'h00;
        end else if (state == FBC_DATA) begin
            burst_addr_out <= (base_addr & ~cur_mask) | ((base_addr + offset) & cur_mask);
        end else begin
            burst_addr_out <= 8'h00;
        end
    end

    // data phase marker
    // registered to line up with the beat address and the strobe
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            data_phase_out <= 1'b0;
        end else begin
            data_phase_out <= (state == FBC_DATA);
        end
    end

    // dual error stall, held for the rest of the transaction
    // stays set so a single error pulse keeps the strobe down to the end
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            stalled <= 1'b0;
        end else if (state == FBC_IDLE) begin
            stalled <= 1'b0;
        end else if (dual_err_in && !vcr_word[FBC_STALL_BIT]) begin
            stalled <= 1'b1;
        end
    end

    // read strobe toggles each data cycle unless stalled low
    // the first beat shows high, so the host sees a rising edge on the first word
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            strobe <= 1'b0;
        end else if (state == FBC_DATA && !stalled) begin
            strobe <= !strobe;
        end else begin
            strobe <= 1'b0;
        end
    end

    // strobe output
    assign read_write_data_strobe_out = strobe;

endmodule

// >>> verification/fbc_config_regs_properties.sv
// port assertions of the bus configuration register bank
`timescale 1ns/1ps
module fbc_config_regs_properties
    import fbc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    // activity and burst
    input wire logic op_busy_in,
    input wire logic txn_active_in,
    input wire logic [7:0] burst_addr_out,
    input wire logic data_phase_out,
    input wire logic read_write_data_strobe_out,
    // decoded settings
    input wire logic [2:0] drive_strength_out,
    input wire logic secure_silicon_region_locked_out,
    input wire logic [1:0] sector_map_out,
    input wire logic [4:0] read_latency_out,
    input wire logic [7:0] wrap_mask_out,
    input wire logic config_source_vcr_out,
    input wire logic config_locked_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // volatile load that must be taken: unlocked, idle, no write just before
    sequence s_load_ok;
        reg_wr_in && reg_addr_in == FBC_ADDR_VCR && !config_locked_out && !op_busy_in && !txn_active_in
            && !$past(txn_active_in) && !$past(reg_wr_in) && $past(rst_b_in, 2);
    endsequence
    // volatile load that must be ignored
    sequence s_load_blocked;
        reg_wr_in && reg_addr_in == FBC_ADDR_VCR && (config_locked_out || op_busy_in);
    endsequence

    a_latency_range:
    assert property (read_latency_out >= 5'h05 && read_latency_out <= 5'h10)
        else $error("read latency outside five to sixteen");
    a_mask_codes:
    assert property (wrap_mask_out inside {8'h07, 8'h0f, 8'h1f})
        else $error("wrap mask not a burst length");
    a_source_reset:
    assert property ($rose(rst_b_in) |-> !config_source_vcr_out)
        else $error("volatile source after hardware reset");
    a_source_kept:
    assert property (config_source_vcr_out |=> config_source_vcr_out)
        else $error("volatile source dropped without reset");
    a_load_applies:
    assert property (s_load_ok |-> ##2 config_source_vcr_out && {drive_strength_out,
        ~secure_silicon_region_locked_out, sector_map_out} == $past({reg_wdata_in[14:12], reg_wdata_in[10:8]}, 2))
        else $error("volatile load not applied");
    a_load_blocked:
    assert property (s_load_blocked |-> ##2 $stable({drive_strength_out, sector_map_out, read_latency_out}))
        else $error("refused load changed settings");
    a_strobe_in_data:
    assert property (read_write_data_strobe_out |-> data_phase_out)
        else $error("strobe outside data phase");
    a_strobe_toggle:
    assert property (data_phase_out && $past(data_phase_out) && $past(read_write_data_strobe_out)
        |-> !read_write_data_strobe_out)
        else $error("strobe high two beats");
    a_beat_step:
    assert property (data_phase_out && $past(data_phase_out)
        |-> ((burst_addr_out - $past(burst_addr_out)) & wrap_mask_out) == 8'h01)
        else $error("beat address step wrong");
endmodule

// >>> verification/fbc_host_model.sv
// host controller model that opens read bursts and captures beats
`timescale 1ns/1ps
module fbc_host_model (
    // clock and bank outputs
    input wire logic clk_in,
    input wire logic data_phase_in,
    input wire logic strobe_in,
    input wire logic [7:0] beat_addr_in,
    // transaction drive
    output logic txn_out,
    output logic start_out,
    output logic wrap_out,
    output logic err_out,
    output logic [7:0] addr_out
);
    logic [7:0] cap_a [0:15];
    logic cap_s [0:15];
    int lat;

    // quiet bus at time zero
    initial begin
        txn_out = 1'b0;
        start_out = 1'b0;
        wrap_out = 1'b0;
        err_out = 1'b0;
        addr_out = 8'h00;
    end

    // open, start, count wait cycles, capture beats, close
    task automatic run_burst(input logic w, input logic [7:0] base, input int n, input int eb);
        int i;
        @(posedge clk_in);
        txn_out <= 1'b1;
        start_out <= 1'b1;
        wrap_out <= w;
        addr_out <= base;
        @(posedge clk_in);
        start_out <= 1'b0;
        addr_out <= ~base; // no longer qualified
        wrap_out <= ~w;
        lat = 1;
        @(negedge clk_in);
        while (data_phase_in !== 1'b1 && lat < 40) begin
            @(negedge clk_in);
            lat++;
        end
        for (i = 0; i < n; i++) begin
            cap_a[i] = beat_addr_in;
            cap_s[i] = strobe_in;
            @(posedge clk_in);
            if (i == eb) begin
                err_out <= 1'b1;
            end
            @(negedge clk_in);
        end
        @(posedge clk_in);
        txn_out <= 1'b0;
        err_out <= 1'b0;
        @(posedge clk_in);
    endtask
endmodule

// >>> verification/fbc_config_regs_tb_top.sv
// self-checking bench of the bus configuration register bank
`timescale 1ns/1ps
module fbc_config_regs_tb_top
    import fbc_pkg::*;
();
    logic clk_in, rst_b_in, por_b_in, reg_wr_in, reg_rd_in, op_busy_in, txn_active_in, burst_start_in;
    logic burst_wrap_in, dual_err_in, data_phase_out, read_write_data_strobe_out, secure_silicon_region_locked_out;
    logic config_source_vcr_out, config_locked_out;
    logic [3:0] reg_addr_in, lc;
    logic [15:0] reg_wdata_in, reg_rdata_out, w;
    logic [7:0] burst_addr_in, burst_addr_out, wrap_mask_out;
    logic [7:0] masks [0:3] = '{8'h0f, 8'h1f, 8'h07, 8'h0f};
    logic [2:0] drive_strength_out;
    logic [1:0] sector_map_out;
    logic [4:0] read_latency_out;
    int fails = 0;
    int num_checks = 0;
    int i;

    // design and host model
    fbc_config_regs fbc_config_regs_i (.clk_in, .rst_b_in, .por_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .op_busy_in, .txn_active_in, .burst_start_in, .burst_wrap_in, .burst_addr_in,
        .dual_err_in, .burst_addr_out, .data_phase_out, .read_write_data_strobe_out, .drive_strength_out,
        .secure_silicon_region_locked_out, .sector_map_out, .read_latency_out, .wrap_mask_out,
        .config_source_vcr_out, .config_locked_out);
    fbc_host_model fbc_host_model_i (.clk_in, .data_phase_in(data_phase_out), .strobe_in(read_write_data_strobe_out),
        .beat_addr_in(burst_addr_out), .txn_out(txn_active_in), .start_out(burst_start_in),
        .wrap_out(burst_wrap_in), .err_out(dual_err_in), .addr_out(burst_addr_in));

    // 10 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        chk(reg_rdata_out, exp);
    endtask
    // decoded settings and wrap mask
    task automatic dec(input logic [2:0] d, input logic s, input logic [1:0] mp, input logic [4:0] l,
        input logic src, input logic lk, input logic [7:0] m);
        chk({drive_strength_out, secure_silicon_region_locked_out, sector_map_out, read_latency_out,
            config_source_vcr_out, config_locked_out}, {d, s, mp, l, src, lk});
        chk({8'h00, wrap_mask_out}, {8'h00, m});
    endtask
    // one burst: wait length, beat addresses, strobe toggling or stall
    task automatic bchk(input logic wp, input logic [7:0] base, input logic [7:0] m, input int lat, input int eb,
        input logic stall);
        int k;
        logic [7:0] e;
        fbc_host_model_i.run_burst(wp, base, 12, eb);
        chk(16'(fbc_host_model_i.lat), 16'(lat + 2));
        for (k = 0; k < 12; k++) begin
            // linear step, pulled back one window once it leaves the start window
            e = base + k[7:0];
            if (((e ^ base) & ~m) != 8'h00) begin
                e = e - (m + 8'h01);
            end
            chk({8'h00, fbc_host_model_i.cap_a[k]}, {8'h00, e});
            if (!stall || k <= eb + 2) begin
                chk({15'h0000, fbc_host_model_i.cap_s[k]}, {15'h0000, ~k[0]});
            end else begin
                chk({15'h0000, fbc_host_model_i.cap_s[k]}, 16'h0000);
            end
        end
    endtask
    task automatic print_verdict();
        if (fails == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog against a hung burst
    initial begin
        repeat (4000) @(posedge clk_in);
        fails++;
        print_verdict();
    end

    // test sequence
    initial begin
        {rst_b_in, por_b_in, reg_wr_in, reg_rd_in, op_busy_in} = 5'h00;
        reg_addr_in = 4'h0;
        reg_wdata_in = 16'h0000;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        por_b_in <= 1'b1;
        rd(FBC_ADDR_NV, 16'h8ebb);
        rd(FBC_ADDR_VCR, 16'h8ebb);
        rd(FBC_ADDR_STATUS, 16'h0000);
        dec(3'h0, 1'b0, 2'h2, 5'h10, 1'b0, 1'b0, 8'h0f);
        wr(4'hf, 16'h1234);
        rd(4'hf, 16'h0000);
        wr(FBC_ADDR_NV, 16'h0a21);
        rd(FBC_ADDR_NV, 16'h8a29);
        rd(FBC_ADDR_VCR, 16'h8a29);
        chk({11'h000, read_latency_out}, 16'h0007);
        for (i = 0; i < 8; i++) begin
            lc = (i == 7) ? 4'hb : {1'b0, i[2:0]};
            w = {1'b0, i[2:0], 1'b1, ~i[0], i[1:0], lc, 1'b0, i[2], i[1:0]};
            wr(FBC_ADDR_VCR, w);
            rd(FBC_ADDR_VCR, w | 16'h8008);
            dec(i[2:0], i[0], i[1:0], {1'b0, lc} + 5'h05, 1'b1, 1'b0, masks[i[1:0]]);
        end
        @(posedge clk_in);
        op_busy_in <= 1'b1;
        wr(FBC_ADDR_VCR, 16'h0000);
        rd(FBC_ADDR_STATUS, 16'h0019);
        @(posedge clk_in);
        op_busy_in <= 1'b0;
        rd(FBC_ADDR_VCR, 16'hfbbf);
        rd(FBC_ADDR_STATUS, 16'h0009);
        wr(FBC_ADDR_CTRL, 16'h0001);
        rd(FBC_ADDR_STATUS, 16'h0001);
        wr(FBC_ADDR_NV_ERASE, 16'h1234);
        rd(FBC_ADDR_NV, 16'h8ebb);
        wr(FBC_ADDR_NV, 16'h0221);
        rd(FBC_ADDR_NV, 16'h8229);
        rd(FBC_ADDR_VCR, 16'hfbbf);
        dec(3'h7, 1'b1, 2'h3, 5'h10, 1'b1, 1'b0, 8'h0f);
        wr(FBC_ADDR_VCR, 16'h8a0a);
        bchk(1'b1, 8'h0c, 8'h07, 5, -1, 1'b0);
        bchk(1'b0, 8'hfd, 8'hff, 5, -1, 1'b0);
        bchk(1'b1, 8'h0c, 8'h07, 5, 3, 1'b1);
        wr(FBC_ADDR_VCR, 16'h8afd);
        bchk(1'b1, 8'h2e, 8'h1f, 16, 3, 1'b0);
        wr(FBC_ADDR_VCR, 16'h8a3b);
        bchk(1'b1, 8'h1e, 8'h0f, 8, -1, 1'b0);
        wr(FBC_ADDR_VCR, 16'h0000);
        rd(FBC_ADDR_STATUS, 16'h0007);
        dec(3'h0, 1'b1, 2'h0, 5'h05, 1'b1, 1'b1, 8'h0f);
        wr(FBC_ADDR_VCR, 16'hffff);
        wr(FBC_ADDR_NV_ERASE, 16'h0000);
        rd(FBC_ADDR_VCR, 16'h8008);
        rd(FBC_ADDR_NV, 16'h8229);
        rd(FBC_ADDR_STATUS, 16'h000f);
        wr(FBC_ADDR_CTRL, 16'h0001);
        rd(FBC_ADDR_STATUS, 16'h0007);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rd(FBC_ADDR_VCR, 16'h8229);
        rd(FBC_ADDR_STATUS, 16'h0006);
        dec(3'h0, 1'b1, 2'h2, 5'h07, 1'b0, 1'b1, 8'h1f);
        wr(FBC_ADDR_VCR, 16'h8ebb);
        rd(FBC_ADDR_VCR, 16'h8229);
        print_verdict();
    end
endmodule

// attach the port assertions to the bank
bind fbc_config_regs fbc_config_regs_properties fbc_config_regs_properties_i (.clk_in, .rst_b_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .op_busy_in, .txn_active_in, .burst_addr_out, .data_phase_out,
    .read_write_data_strobe_out, .drive_strength_out, .secure_silicon_region_locked_out, .sector_map_out,
    .read_latency_out, .wrap_mask_out, .config_source_vcr_out, .config_locked_out);
